// ---- src/tcm_timer.sv ----
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module tcm_timer #(
   parameter int CW = 16
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          debug_halt,
   input  wire logic          fixed_clk_tick,
   input  wire logic          ext_clk_in,
   input  wire logic          channel_in,
   output logic               overflow_irq,
   output logic               channel_irq,
   output logic               count_down
);
   //==============================================================
   // address decode
   function automatic tcm_pkg::tcm_reg_t decode(input logic [7:0] a);
      unique case (a)
         tcm_pkg::TCM_OFS_SC:   decode = tcm_pkg::TCM_R_SC;
         tcm_pkg::TCM_OFS_CNTH: decode = tcm_pkg::TCM_R_CNTH;
         tcm_pkg::TCM_OFS_CNTL: decode = tcm_pkg::TCM_R_CNTL;
         tcm_pkg::TCM_OFS_MODH: decode = tcm_pkg::TCM_R_MODH;
         tcm_pkg::TCM_OFS_MODL: decode = tcm_pkg::TCM_R_MODL;
         tcm_pkg::TCM_OFS_CSC:  decode = tcm_pkg::TCM_R_CSC;
         tcm_pkg::TCM_OFS_CHV:  decode = tcm_pkg::TCM_R_CHV;
         default:               decode = tcm_pkg::TCM_R_NONE;
      endcase
   endfunction

   tcm_pkg::tcm_reg_t sel;
   logic              setup_rd;
   logic              acc_wr;
   logic [7:0]        wbyte;

   assign sel      = decode(paddr);
   assign setup_rd = psel && !penable && !pwrite;
   assign acc_wr   = psel && penable && pwrite;
   assign wbyte    = pwdata[7:0];
   // no wait states: every access completes in two cycles
   assign pready   = 1'b1;

   logic wr_sc, wr_cnt, wr_modh, wr_modl, wr_csc, wr_chv;
   logic rd_sc, rd_cnth, rd_cntl, rd_csc;
   assign wr_sc   = acc_wr && (sel == tcm_pkg::TCM_R_SC);
   assign wr_cnt  = acc_wr && ((sel == tcm_pkg::TCM_R_CNTH) ||
                               (sel == tcm_pkg::TCM_R_CNTL));
   assign wr_modh = acc_wr && (sel == tcm_pkg::TCM_R_MODH);
   assign wr_modl = acc_wr && (sel == tcm_pkg::TCM_R_MODL);
   assign wr_csc  = acc_wr && (sel == tcm_pkg::TCM_R_CSC);
   assign wr_chv  = acc_wr && (sel == tcm_pkg::TCM_R_CHV);
   assign rd_sc   = setup_rd && (sel == tcm_pkg::TCM_R_SC);
   assign rd_cnth = setup_rd && (sel == tcm_pkg::TCM_R_CNTH);
   assign rd_cntl = setup_rd && (sel == tcm_pkg::TCM_R_CNTL);
   assign rd_csc  = setup_rd && (sel == tcm_pkg::TCM_R_CSC);

   //==============================================================
   // control registers
   logic          ovf_reg, ovf_ie_reg, cpwm_reg;
   logic [1:0]    clks_reg;
   logic [2:0]    ps_reg;
   logic          chf_reg, ch_ie_reg, msb_reg, msa_reg;
   logic [CW-1:0] chv_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_ie_reg <= 1'b0;
         cpwm_reg   <= 1'b0;
         clks_reg   <= tcm_pkg::TCM_CLK_OFF;
         ps_reg     <= '0;
      end else if (wr_sc) begin
         ovf_ie_reg <= wbyte[tcm_pkg::TCM_SC_IE];
         cpwm_reg   <= wbyte[tcm_pkg::TCM_SC_CPWM];
         clks_reg   <= wbyte[tcm_pkg::TCM_SC_CLK_H:tcm_pkg::TCM_SC_CLK_L];
         ps_reg     <= wbyte[tcm_pkg::TCM_SC_PS_H:tcm_pkg::TCM_SC_PS_L];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ch_ie_reg <= 1'b0;
         msb_reg   <= 1'b0;
         msa_reg   <= 1'b0;
      end else if (wr_csc) begin
         ch_ie_reg <= wbyte[tcm_pkg::TCM_CSC_IE];
         msb_reg   <= wbyte[tcm_pkg::TCM_CSC_MSB];
         msa_reg   <= wbyte[tcm_pkg::TCM_CSC_MSA];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         chv_reg <= '0;
      else if (wr_chv)
         chv_reg <= pwdata[CW-1:0];
   end

   //==============================================================
   // clock source and prescaler
   logic       ext_prev_reg;
   logic       src_tick;
   logic [6:0] pre_reg;
   logic [6:0] pre_mask;
   logic       tick;
   logic       run;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ext_prev_reg <= 1'b0;
      else
         ext_prev_reg <= ext_clk_in;
   end

   always_comb begin
      unique case (clks_reg)
         tcm_pkg::TCM_CLK_OFF:   src_tick = 1'b0;
         tcm_pkg::TCM_CLK_BUS:   src_tick = 1'b1;
         tcm_pkg::TCM_CLK_FIXED: src_tick = fixed_clk_tick;
         tcm_pkg::TCM_CLK_EXT:   src_tick = ext_clk_in && !ext_prev_reg;
      endcase
   end

   // halt stops the prescaler too so no partial period leaks out
   assign run      = src_tick && !debug_halt;
   assign pre_mask = (tcm_pkg::TCM_PRE_ONE << ps_reg) - tcm_pkg::TCM_PRE_ONE;
   assign tick     = run && ((pre_reg & pre_mask) == pre_mask);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pre_reg <= '0;
      else if (run)
         pre_reg <= pre_reg + tcm_pkg::TCM_PRE_ONE;
   end

   //==============================================================
   // counter
   logic [CW-1:0] cnt_reg, cnt_next, mod_reg, mod_buf_reg, top;
   logic          dir_down_reg, dir_down_next;
   logic          wrap;
   logic          modh_wr_reg, modl_wr_reg;

   // zero modulo means the counter spans its whole range
   assign top = (mod_reg == '0) ? '1 : mod_reg;

   always_comb begin
      // center mode flags the overflow at the turnaround from the top
      cnt_next      = cnt_reg;
      dir_down_next = dir_down_reg;
      wrap          = 1'b0;
      if (tick) begin
         if (!cpwm_reg) begin
            if (cnt_reg == top) begin
               cnt_next = '0;
               wrap     = 1'b1;
            end else begin
               cnt_next = cnt_reg + CW'(1);
            end
         end else if (!dir_down_reg) begin
            if (cnt_reg >= top) begin
               cnt_next      = cnt_reg - CW'(1);
               dir_down_next = 1'b1;
               wrap          = 1'b1;
            end else begin
               cnt_next = cnt_reg + CW'(1);
            end
         end else if (cnt_reg == '0) begin
            cnt_next      = CW'(1);
            dir_down_next = 1'b0;
         end else begin
            cnt_next = cnt_reg - CW'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg      <= '0;
         dir_down_reg <= 1'b0;
      end else if (wr_cnt) begin
         cnt_reg      <= '0;
         dir_down_reg <= 1'b0;
      end else begin
         cnt_reg      <= cnt_next;
         dir_down_reg <= dir_down_next;
      end
   end
   assign count_down = dir_down_reg;

   //==============================================================
   // coherent counter read
   logic          lat_valid_reg, lat_hi_reg, lat_lo_reg;
   logic [CW-1:0] lat_val_reg;
   logic [CW-1:0] cnt_view;

   // in halt the live frozen value is read and the latch untouched
   assign cnt_view = (lat_valid_reg && !debug_halt) ? lat_val_reg
                                                    : cnt_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lat_valid_reg <= 1'b0;
         lat_hi_reg    <= 1'b0;
         lat_lo_reg    <= 1'b0;
         lat_val_reg   <= '0;
      end else if (wr_sc || wr_cnt) begin
         lat_valid_reg <= 1'b0;
         lat_hi_reg    <= 1'b0;
         lat_lo_reg    <= 1'b0;
      end else if ((rd_cnth || rd_cntl) && !debug_halt) begin
         if (!lat_valid_reg) begin
            lat_valid_reg <= 1'b1;
            lat_val_reg   <= cnt_reg;
            lat_hi_reg    <= rd_cnth;
            lat_lo_reg    <= rd_cntl;
         end else if ((rd_cnth && lat_lo_reg) || (rd_cntl && lat_hi_reg))
         begin
            lat_valid_reg <= 1'b0;
            lat_hi_reg    <= 1'b0;
            lat_lo_reg    <= 1'b0;
         end
      end
   end

   //==============================================================
   // modulo buffer
   logic both_wr, half_wr, apply_run, apply_idle;

   assign both_wr    = modh_wr_reg && modl_wr_reg;
   assign half_wr    = modh_wr_reg ^ modl_wr_reg;
   assign apply_idle = (clks_reg == tcm_pkg::TCM_CLK_OFF) && !debug_halt &&
                       ((wr_modh && modl_wr_reg) || (wr_modl && modh_wr_reg));
   // free running top is all ones, so this also covers 0xFFFE to 0xFFFF
   assign apply_run  = both_wr && tick && !cpwm_reg &&
                       (cnt_next == top) && (cnt_reg != top);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         modh_wr_reg <= 1'b0;
         modl_wr_reg <= 1'b0;
         mod_buf_reg <= '0;
      end else if (wr_sc) begin
         modh_wr_reg <= 1'b0;
         modl_wr_reg <= 1'b0;
      end else if (debug_halt) begin
         modh_wr_reg <= modh_wr_reg;
      end else if (apply_idle || apply_run) begin
         modh_wr_reg <= 1'b0;
         modl_wr_reg <= 1'b0;
      end else if (wr_modh) begin
         modh_wr_reg      <= 1'b1;
         mod_buf_reg[15:8] <= wbyte;
      end else if (wr_modl) begin
         modl_wr_reg     <= 1'b1;
         mod_buf_reg[7:0] <= wbyte;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         mod_reg <= '0;
      else if (debug_halt && wr_modh)
         mod_reg[15:8] <= wbyte;
      else if (debug_halt && wr_modl)
         mod_reg[7:0] <= wbyte;
      else if (apply_idle && wr_modh)
         mod_reg <= {wbyte, mod_buf_reg[7:0]};
      else if (apply_idle && wr_modl)
         mod_reg <= {mod_buf_reg[15:8], wbyte};
      else if (apply_run)
         mod_reg <= mod_buf_reg;
   end

   //==============================================================
   // overflow flag with read-then-write-zero clear
   logic ovf_set, ovf_arm_reg;

   // a half-written modulo could wrap at a stale top, so hold the flag off
   assign ovf_set = wrap && !half_wr;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_reg     <= 1'b0;
         ovf_arm_reg <= 1'b0;
      end else if (ovf_set) begin
         ovf_reg     <= 1'b1; // set wins over a clear
         ovf_arm_reg <= 1'b0;
      end else if (wr_sc) begin
         if (ovf_arm_reg && !wbyte[tcm_pkg::TCM_SC_FLAG])
            ovf_reg <= 1'b0;
         ovf_arm_reg <= 1'b0;
      end else if (rd_sc && ovf_reg) begin
         ovf_arm_reg <= 1'b1;
      end
   end
   assign overflow_irq = ovf_reg && ovf_ie_reg;

   //==============================================================
   // channel event
   logic ch_prev_reg, mode_cap, mode_cmp, mode_pwm, duty_edge, ch_set;
   logic ch_arm_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ch_prev_reg <= 1'b0;
      else
         ch_prev_reg <= channel_in;
   end

   assign mode_cap  = !cpwm_reg && !msb_reg && !msa_reg;
   assign mode_cmp  = !cpwm_reg && !msb_reg && msa_reg;
   assign mode_pwm  = cpwm_reg || msb_reg;
   // duty 0% or 100%: value zero or past the top of the period
   assign duty_edge = (chv_reg == '0) || (chv_reg > top);
   assign ch_set    = (mode_cap && channel_in && !ch_prev_reg) ||
                      (tick && (cnt_next == chv_reg) &&
                       (mode_cmp || (mode_pwm && !duty_edge)));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chf_reg    <= 1'b0;
         ch_arm_reg <= 1'b0;
      end else if (ch_set) begin
         chf_reg    <= 1'b1; // set wins over a clear
         ch_arm_reg <= 1'b0;
      end else if (wr_csc) begin
         if (ch_arm_reg && !wbyte[tcm_pkg::TCM_CSC_FLAG])
            chf_reg <= 1'b0;
         ch_arm_reg <= 1'b0;
      end else if (rd_csc && chf_reg) begin
         ch_arm_reg <= 1'b1;
      end
   end
   assign channel_irq = chf_reg && ch_ie_reg;

   //==============================================================
   // read data, captured at the setup edge
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = '0;
      unique case (sel)
         tcm_pkg::TCM_R_SC:   rd_mux[7:0] = {ovf_reg, ovf_ie_reg, cpwm_reg,
                                             clks_reg, ps_reg};
         tcm_pkg::TCM_R_CNTH: rd_mux[7:0] = cnt_view[15:8];
         tcm_pkg::TCM_R_CNTL: rd_mux[7:0] = cnt_view[7:0];
         tcm_pkg::TCM_R_MODH: rd_mux[7:0] = mod_reg[15:8];
         tcm_pkg::TCM_R_MODL: rd_mux[7:0] = mod_reg[7:0];
         tcm_pkg::TCM_R_CSC:  rd_mux[7:0] = {chf_reg, ch_ie_reg, msb_reg,
                                             msa_reg, 4'h0};
         tcm_pkg::TCM_R_CHV:  rd_mux[CW-1:0] = chv_reg;
         tcm_pkg::TCM_R_NONE: rd_mux = '0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      // read side effects also fire here, so data and latch agree
      end else if (psel && !penable) begin
         prdata  <= pwrite ? '0 : rd_mux;
         pslverr <= (sel == tcm_pkg::TCM_R_NONE);
      end
   end
endmodule

// ---- src/tcm_pkg.sv ----
//==============================================================
// Contract
// - clock source selects off, bus, fixed, external
// - prescaler divides by two to the field
// - counter byte read latches full snapshot
// - reset or status write restarts read latch
// - reset or counter byte write clears counter
// - debug halt freezes counter and read latch
// - halt writes to status or counter restart latch
// - edge mode: counter at modulo wraps to zero, sets overflow
// - half modulo write suppresses overflow flag
// - modulo resets zero, zero means free running
// - clock off: modulo applied on second byte
// - clock on, edge mode: modulo applied stepping onto top; never in center mode
// - status write resets modulo write latch
// - halt modulo writes go direct, latch kept
// - channel flag on capture edge or match
// - no channel flag at 0% or 100% duty
// - channel irq is flag and enable bit 6
// - read-then-write-zero clears channel flag
// - reset clears channel flag and enable
// - mode select b bit 5 gives edge pwm
// - overflow irq is flag and enable
// - center select makes counter count up/down
package tcm_pkg;
   //==============================================================
   // register map, byte addresses
   localparam logic [7:0] TCM_OFS_SC   = 8'h00;
   localparam logic [7:0] TCM_OFS_CNTH = 8'h04;
   localparam logic [7:0] TCM_OFS_CNTL = 8'h08;
   localparam logic [7:0] TCM_OFS_MODH = 8'h0C;
   localparam logic [7:0] TCM_OFS_MODL = 8'h10;
   localparam logic [7:0] TCM_OFS_CSC  = 8'h14;
   localparam logic [7:0] TCM_OFS_CHV  = 8'h18;

   typedef enum logic [2:0] {
      TCM_R_SC, TCM_R_CNTH, TCM_R_CNTL, TCM_R_MODH,
      TCM_R_MODL, TCM_R_CSC, TCM_R_CHV, TCM_R_NONE
   } tcm_reg_t;

   //==============================================================
   // field positions
   localparam int TCM_SC_FLAG  = 7;
   localparam int TCM_SC_IE    = 6;
   localparam int TCM_SC_CPWM  = 5;
   localparam int TCM_SC_CLK_H = 4;
   localparam int TCM_SC_CLK_L = 3;
   localparam int TCM_SC_PS_H  = 2;
   localparam int TCM_SC_PS_L  = 0;
   localparam int TCM_CSC_FLAG = 7;
   localparam int TCM_CSC_IE   = 6;
   localparam int TCM_CSC_MSB  = 5;
   localparam int TCM_CSC_MSA  = 4;

   //==============================================================
   // encodings and values
   localparam logic [1:0]  TCM_CLK_OFF   = 2'h0;
   localparam logic [1:0]  TCM_CLK_BUS   = 2'h1;
   localparam logic [1:0]  TCM_CLK_FIXED = 2'h2;
   localparam logic [1:0]  TCM_CLK_EXT   = 2'h3;
   localparam logic [15:0] TCM_ZERO16    = 16'h0000;
   localparam logic [15:0] TCM_FULL16    = 16'hFFFF;
   localparam logic [15:0] TCM_ONE16     = 16'h0001;
   localparam logic [7:0]  TCM_ZERO8     = 8'h00;
   localparam logic [6:0]  TCM_PRE_ONE   = 7'h01;
endpackage

// ---- bench/tcm_timer_chk.sv ----
`timescale 1ns/1ps
module tcm_timer_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        overflow_irq,
   input wire logic        channel_irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc;
   logic map_ok;
   logic csc_wr;
   logic sc_wr;
   assign acc    = psel && penable;
   assign map_ok = (paddr <= tcm_pkg::TCM_OFS_CHV) && (paddr[1:0] == 2'h0);
   assign csc_wr = acc && pwrite && (paddr == tcm_pkg::TCM_OFS_CSC);
   assign sc_wr  = acc && pwrite && (paddr == tcm_pkg::TCM_OFS_SC);
   //==============================================================
   // bus answers
   property p_ready; acc |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("pready low in access");
   property p_err_bad; acc && !map_ok |-> pslverr; endproperty
   a_err_bad: assert property (p_err_bad) else $error("no error on hole");
   property p_err_ok; acc && map_ok |-> !pslverr; endproperty
   a_err_ok: assert property (p_err_ok) else $error("error on mapped reg");
   property p_rd_bad; acc && !pwrite && !map_ok |-> prdata == 32'h0000_0000;
   endproperty
   a_rd_bad: assert property (p_rd_bad) else $error("hole read not zero");
   //==============================================================
   // interrupt requests
   property p_ch_ie_off; csc_wr && !pwdata[6] |=> !channel_irq; endproperty
   a_ch_ie_off: assert property (p_ch_ie_off)
      else $error("channel irq with enable off");
   property p_ov_ie_off; sc_wr && !pwdata[6] |=> !overflow_irq; endproperty
   a_ov_ie_off: assert property (p_ov_ie_off)
      else $error("overflow irq with enable off");
   property p_ch_fall; $fell(channel_irq) |-> $past(csc_wr); endproperty
   a_ch_fall: assert property (p_ch_fall)
      else $error("channel irq dropped without write");
   property p_ov_fall; $fell(overflow_irq) |-> $past(sc_wr); endproperty
   a_ov_fall: assert property (p_ov_fall)
      else $error("overflow irq dropped without write");
   property p_ch_hold;
      csc_wr && channel_irq && pwdata[7] && pwdata[6] |=> channel_irq;
   endproperty
   a_ch_hold: assert property (p_ch_hold)
      else $error("writing one cleared channel flag");
endmodule

bind tcm_timer tcm_timer_chk tcm_timer_chk_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .overflow_irq(overflow_irq),
   .channel_irq(channel_irq)
);

// ---- bench/tcm_timer_bench.sv ----
`timescale 1ns/1ps
module tcm_timer_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        debug_halt, fixed_clk_tick, ext_clk_in, channel_in;
   logic        overflow_irq, channel_irq, slv_err, count_down;
   logic [7:0]  paddr, junk;
   logic [31:0] pwdata, prdata;
   int          bad_count = 0;
   int          checks = 0;

   tcm_timer tcm_timer_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .debug_halt(debug_halt),
      .fixed_clk_tick(fixed_clk_tick), .ext_clk_in(ext_clk_in),
      .channel_in(channel_in), .overflow_irq(overflow_irq),
      .channel_irq(channel_irq), .count_down(count_down)
   );

   //==============================================================
   // shared tasks
   task automatic check(input string nm, input logic [7:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic xfer(input logic w, input logic [7:0] a, d,
                       output logic [7:0] r);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      r = prdata[7:0];
      slv_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, d);
      xfer(1'b1, a, d, junk);
   endtask

   task automatic rd_chk(input logic [7:0] a, exp);
      logic [7:0] v;
      xfer(1'b0, a, 8'h00, v);
      check($sformatf("reg %h", a), v, exp);
   endtask

   task automatic ticks(input int n);
      repeat (n) begin
         fixed_clk_tick <= 1'b1;
         @(posedge pclk);
         fixed_clk_tick <= 1'b0;
         @(posedge pclk);
      end
      repeat (4) @(posedge pclk);
   endtask

   task automatic wait_ovf(input int max);
      int n;
      n = 0;
      while (overflow_irq !== 1'b1 && n < max) begin
         @(posedge pclk);
         n++;
      end
   endtask

   //==============================================================
   // scenarios
   task automatic t_sources();
      wr(tcm_pkg::TCM_OFS_SC, 8'h12);
      ticks(8);
      wr(tcm_pkg::TCM_OFS_SC, 8'h00);
      rd_chk(tcm_pkg::TCM_OFS_CNTL, 8'h02);
      wr(tcm_pkg::TCM_OFS_CNTH, 8'hA5);
      wr(tcm_pkg::TCM_OFS_SC, 8'h18);
      repeat (3) begin
         ext_clk_in <= 1'b1;
         repeat (4) @(posedge pclk);
         ext_clk_in <= 1'b0;
         repeat (4) @(posedge pclk);
      end
      wr(tcm_pkg::TCM_OFS_SC, 8'h00);
      ticks(2);
      rd_chk(tcm_pkg::TCM_OFS_CNTL, 8'h03);
      rd_chk(tcm_pkg::TCM_OFS_CNTH, 8'h00);
   endtask

   task automatic t_latch();
      wr(tcm_pkg::TCM_OFS_SC, 8'h10);
      wr(tcm_pkg::TCM_OFS_CNTH, 8'h00);
      ticks(5);
      rd_chk(tcm_pkg::TCM_OFS_CNTH, 8'h00);
      ticks(2);
      rd_chk(tcm_pkg::TCM_OFS_CNTL, 8'h05);
      rd_chk(tcm_pkg::TCM_OFS_CNTL, 8'h07);
      ticks(2);
      wr(tcm_pkg::TCM_OFS_SC, 8'h10);
      rd_chk(tcm_pkg::TCM_OFS_CNTH, 8'h00);
      debug_halt <= 1'b1;
      rd_chk(tcm_pkg::TCM_OFS_CNTH, 8'h00);
      ticks(3);
      rd_chk(tcm_pkg::TCM_OFS_CNTL, 8'h09);
      debug_halt <= 1'b0;
      ticks(2);
      rd_chk(tcm_pkg::TCM_OFS_CNTL, 8'h09);
      wr(tcm_pkg::TCM_OFS_CNTL, 8'h55);
      rd_chk(tcm_pkg::TCM_OFS_CNTL, 8'h00);
   endtask

   task automatic t_modulo();
      wr(tcm_pkg::TCM_OFS_SC, 8'h00);
      wr(tcm_pkg::TCM_OFS_MODH, 8'h00);
      wr(tcm_pkg::TCM_OFS_MODL, 8'hFF);
      rd_chk(tcm_pkg::TCM_OFS_MODL, 8'hFF);
      wr(tcm_pkg::TCM_OFS_CNTH, 8'h00);
      wr(tcm_pkg::TCM_OFS_SC, 8'h48);
      wait_ovf(300);
      check("ovf irq", overflow_irq, 1'b1);
      rd_chk(tcm_pkg::TCM_OFS_SC, 8'hC8);
      wr(tcm_pkg::TCM_OFS_SC, 8'h48);
      check("ovf clear", overflow_irq, 1'b0);
      wr(tcm_pkg::TCM_OFS_MODH, 8'h01);
      repeat (600) @(posedge pclk);
      check("ovf held", overflow_irq, 1'b0);
      rd_chk(tcm_pkg::TCM_OFS_MODH, 8'h00);
      wr(tcm_pkg::TCM_OFS_MODL, 8'h00);
      wait_ovf(600);
      check("ovf again", overflow_irq, 1'b1);
      rd_chk(tcm_pkg::TCM_OFS_MODH, 8'h01);
      wr(tcm_pkg::TCM_OFS_SC, 8'h00);
   endtask

   task automatic t_channel();
      wr(tcm_pkg::TCM_OFS_CSC, 8'h40);
      channel_in <= 1'b1;
      repeat (4) @(posedge pclk);
      check("ch irq", channel_irq, 1'b1);
      wr(tcm_pkg::TCM_OFS_CSC, 8'hC0);
      wr(tcm_pkg::TCM_OFS_CSC, 8'h40);
      check("ch no arm", channel_irq, 1'b1);
      rd_chk(tcm_pkg::TCM_OFS_CSC, 8'hC0);
      wr(tcm_pkg::TCM_OFS_CSC, 8'h40);
      check("ch clear", channel_irq, 1'b0);
      channel_in <= 1'b0;
      wr(tcm_pkg::TCM_OFS_CSC, 8'h00);
      xfer(1'b0, 8'h1C, 8'h00, junk);
      check("hole err", slv_err, 1'b1);
      check("hole data", junk, 8'h00);
   endtask

   task automatic t_pwm();
      wr(tcm_pkg::TCM_OFS_CNTH, 8'h00);
      wr(tcm_pkg::TCM_OFS_MODH, 8'h00);
      wr(tcm_pkg::TCM_OFS_MODL, 8'h08);
      wr(tcm_pkg::TCM_OFS_CHV, 8'h05);
      wr(tcm_pkg::TCM_OFS_CSC, 8'h50);
      wr(tcm_pkg::TCM_OFS_SC, 8'h10);
      ticks(5);
      check("ch match", channel_irq, 1'b1);
      rd_chk(tcm_pkg::TCM_OFS_CSC, 8'hD0);
      wr(tcm_pkg::TCM_OFS_CSC, 8'h60);
      check("ch pwm clear", channel_irq, 1'b0);
      wr(tcm_pkg::TCM_OFS_CHV, 8'h00);
      ticks(9);
      check("ch duty zero", channel_irq, 1'b0);
      wr(tcm_pkg::TCM_OFS_CHV, 8'h05);
      ticks(9);
      check("ch pwm match", channel_irq, 1'b1);
      wr(tcm_pkg::TCM_OFS_SC, 8'h30);
      ticks(4);
      check("count down", count_down, 1'b1);
      rd_chk(tcm_pkg::TCM_OFS_CNTL, 8'h07);
      debug_halt <= 1'b1;
      wr(tcm_pkg::TCM_OFS_CNTL, 8'h00);
      debug_halt <= 1'b0;
      ticks(3);
      rd_chk(tcm_pkg::TCM_OFS_CNTL, 8'h03);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk(tcm_pkg::TCM_OFS_CNTL, 8'h00);
      rd_chk(tcm_pkg::TCM_OFS_MODL, 8'h00);
      rd_chk(tcm_pkg::TCM_OFS_CSC, 8'h00);
   endtask

   task automatic give_verdict();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   //==============================================================
   // clock, reset, sequence and watchdog
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      give_verdict();
   end

   initial begin
      logic [7:0] adr [6];
      adr = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
      {presetn, psel, penable, pwrite, debug_halt} <= 5'h00;
      {fixed_clk_tick, ext_clk_in, channel_in} <= 3'h0;
      paddr <= 8'h00;
      pwdata <= 32'h0000_0000;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 6; i++) begin
         rd_chk(adr[i], 8'h00);
      end
      t_sources();
      t_latch();
      t_modulo();
      t_channel();
      t_pwm();
      give_verdict();
   end
endmodule
